// File: shared/ssp_pkg.sv
// Constants and types shared by the SPI serial port design files.
// Assumes a single core clock domain; no other package is needed.
package ssp_pkg;
  // Byte width of one serial transfer.
  localparam int unsigned DATA_BITS = 8;
  // Width of the Wishbone byte address.
  localparam int unsigned ADR_W     = 4;
  // Register byte offsets on the bus.
  localparam logic [3:0] OFS_STATUS  = 4'h0;
  localparam logic [3:0] OFS_CONTROL = 4'h4;
  localparam logic [3:0] OFS_DATA    = 4'h8;
  localparam logic [3:0] OFS_EVENT   = 4'hC;
  // Field positions in the status, control and event registers.
  localparam int unsigned ST_SAMPLE = 7;
  localparam int unsigned ST_EDGE   = 6;
  localparam int unsigned ST_FULL   = 0;
  localparam int unsigned CT_WRITE_COLLISION   = 7;
  localparam int unsigned CT_OVF    = 6;
  localparam int unsigned CT_EN     = 5;
  localparam int unsigned CT_CKP    = 4;
  localparam int unsigned EV_DONE   = 0;
  // Values after reset.
  localparam logic [7:0] RST_STATUS  = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_DATA    = 8'h00;
  // Encodings of the port mode field.
  localparam logic [3:0] MODE_DIV4    = 4'h0;
  localparam logic [3:0] MODE_DIV16   = 4'h1;
  localparam logic [3:0] MODE_DIV64   = 4'h2;
  localparam logic [3:0] MODE_TIMER   = 4'h3;
  localparam logic [3:0] MODE_SLV_SS  = 4'h4;
  localparam logic [3:0] MODE_SLV_PIO = 4'h5;
  // Bit clock dividers of the core clock, and half-period counts from them.
  localparam int unsigned DIV_FAST = 4;
  localparam int unsigned DIV_MID  = 16;
  localparam int unsigned DIV_SLOW = 64;
  localparam logic [4:0] HALF_FAST = 5'(DIV_FAST / 2 - 1);
  localparam logic [4:0] HALF_MID  = 5'(DIV_MID / 2 - 1);
  localparam logic [4:0] HALF_SLOW = 5'(DIV_SLOW / 2 - 1);
  // Last half-period index of a master byte, and last bit index.
  localparam logic [4:0] HALF_LAST = 5'(2 * DATA_BITS);
  localparam logic [2:0] BIT_LAST  = 3'(DATA_BITS - 1);
  // Master shifter states.
  typedef enum logic [1:0] {
    SSP_IDLE  = 2'h0,
    SSP_SHIFT = 2'h1
  } ssp_state_t;
endpackage

// File: design/ssp_sync2.sv
// Two-stage synchroniser for the serial port pins.
// Assumes the inputs are asynchronous to core_clk.
`timescale 1ns/1ps
module ssp_sync2 #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  // First stage; read by the second stage only.
  logic [WIDTH-1:0] metaStage;

  // Both stages advance together while the clock enable is high.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      metaStage <= '0;
      syncOut   <= '0;
    end
    else if (ce)
    begin
      metaStage <= asyncIn;
      syncOut   <= metaStage;
    end
  end
endmodule

// File: design/ssp_clk_div.sv
// Half-period tick generator for the master bit clock.
// Assumes timerPulse is a one-cycle pulse on core_clk.
`timescale 1ns/1ps
module ssp_clk_div
  import ssp_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [3:0] rateSel,
  input  wire logic       timerPulse,
  output logic            halfTick
);
  // Core cycles elapsed in the current half period.
  logic [4:0] count;

  // Maps a rate code onto the last count of a half period.
  function automatic logic [4:0] halfLimit(input logic [3:0] rate);
    unique case (rate)
      MODE_DIV16: halfLimit = HALF_MID;
      MODE_DIV64: halfLimit = HALF_SLOW;
      default:    halfLimit = HALF_FAST;
    endcase
  endfunction

  // Counts core cycles, or passes timer pulses, into half-period ticks.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      count    <= 5'h00;
      halfTick <= 1'b0;
    end
    else if (ce)
    begin
      if (!run)
      begin
        count    <= 5'h00;
        halfTick <= 1'b0;
      end
      else if (rateSel == MODE_TIMER)
      begin
        // Each timer pulse is half a bit, so the bit rate is timer/2.
        halfTick <= timerPulse;
      end
      else if (count == halfLimit(rateSel))
      begin
        count    <= 5'h00;
        halfTick <= 1'b1;
      end
      else
      begin
        count    <= count + 5'h01;
        halfTick <= 1'b0;
      end
    end
  end
endmodule

// File: design/ssp_spi_port.sv
// SPI port: Wishbone registers, master bit engine and slave sampling.
// Assumes a classic Wishbone master on core_clk and pins from outside.
// Function
// [R1] Eight bits out and in; four clock modes.
// [R2] Shift most significant bit first.
// [R3] Master sample phase: middle or end.
// [R4] Software keeps sample phase clear as slave.
// [R5] Clock edge bit picks output change edge.
// [R6] Clock polarity sets serial clock idle level.
// [R7] Modes 0100/0101: slave with/without select.
// [R8] Modes 0011/0010/0001: timer/2, /64, /16.
// [R9] Enable bit hands pins to serial function.
// [R10] Software disables before reconfiguring, then re-enables.
// [R11] Full byte moves to buffer; flags set.
// [R12] Receive path is double buffered.
// [R13] Data write loads buffer and shifter together.
// [R14] Buffer full flag; data read clears it.
// [R15] Write while busy dropped, sets collision flag.
// [R16] Software clears collision flag before next write.
// [R17] Slave byte into full buffer: overflow, dropped.
// [R18] Shifter reached only through the data buffer.
// [R19] Software sets pin directions as expected.
// [R20] Master drives clock; opposite edges shift/capture.
// [R21] Both ends use the same clock polarity.
// [R22] Software reads buffer before next write.
// [R23] Master data write starts exchange at once.
// [R24] Select high releases data out, clears count.
// [R25] Mode 0000 selects core clock divided by four.
// [R26] Disable aborts transfer, idles counter and shifter.
`timescale 1ns/1ps
module ssp_spi_port
  import ssp_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [ssp_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  input  wire logic                     timerOut,
  input  wire logic                     sckIn,
  output logic                          sckOut,
  output logic                          sckOe,
  input  wire logic                     sdiIn,
  output logic                          sdoOut,
  output logic                          sdoOe,
  input  wire logic                     ssN,
  output logic                          pinsSerial
);
  import ssp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic       sampleEnd;       // Sample at end of output time.
  logic       edgeSel;         // Output changes on active-to-idle edge.
  logic       bufferFull;      // Received byte waits in buffer.
  logic       writeCollision;  // Data write came while busy.
  logic       receiveOverflow; // Slave byte lost to full buffer.
  logic       portEnable;      // Port on, pins serial.
  logic       clockPolarity;   // Idle level of the serial clock.
  logic [3:0] portMode;        // Role and bit clock rate.
  logic [7:0] dataBuffer;      // Receive buffer and transmit image.
  logic       transferDone;    // Sticky completion flag.
  logic [7:0] txShift;         // Outgoing half of the shifter.
  logic [7:0] rxShift;         // Incoming half of the shifter.
  logic [2:0] bitCnt;          // Slave bits sampled so far.
  logic [4:0] halfIdx;         // Master half-period index.
  ssp_state_t state;           // Master engine state.
  logic       halfTick;        // Master half-period tick.
  logic       sckS;            // Synchronised serial clock.
  logic       sdiS;            // Synchronised data in.
  logic       ssS;             // Synchronised select, high deselects.
  logic       sckPrev;         // Serial clock one cycle earlier.
  logic [7:0] readMux;         // Read data before registering.

  // Returns true when the address selects the given register.
  function automatic logic regSel(input logic [ADR_W-1:0] adr,
                                  input logic [3:0] ofs);
    regSel = (adr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Mode decoding and bus strobes.
  logic isMaster;  // One of the four master rates.
  logic isSlave;   // One of the two slave modes.
  logic slaveSs;   // Slave with select control.
  logic ssBlock;   // Select holds the slave off.
  logic slaveOn;   // Slave may shift.
  logic busReq;    // Request completing on this edge.
  logic wrData;    // Data buffer write.
  logic rdData;    // Data buffer read.
  logic wrCtrl;    // Control register write.
  logic wrStat;    // Status register write.
  logic wrEvt;     // Event register write.
  logic busy;      // A byte is in flight.
  logic wrOk;      // Data write accepted.

  // A request takes effect on the edge where ack is seen high.
  assign busReq   = wb_cyc_i & wb_stb_i & wb_ack_o;
  assign wrData   = busReq & wb_we_i & wb_sel_i[0] & regSel(wb_adr_i, OFS_DATA);
  assign rdData   = busReq & !wb_we_i & regSel(wb_adr_i, OFS_DATA);
  assign wrCtrl   = busReq & wb_we_i & wb_sel_i[0] & regSel(wb_adr_i, OFS_CONTROL);
  assign wrStat   = busReq & wb_we_i & wb_sel_i[0] & regSel(wb_adr_i, OFS_STATUS);
  assign wrEvt    = busReq & wb_we_i & wb_sel_i[0] & regSel(wb_adr_i, OFS_EVENT);
  // [R7] [R8] [R25] mode field decode
  assign isMaster = portMode <= MODE_TIMER;
  assign isSlave  = (portMode == MODE_SLV_SS) | (portMode == MODE_SLV_PIO);
  assign slaveSs  = portMode == MODE_SLV_SS;
  // [R24] select gating
  assign ssBlock  = slaveSs & ssS;
  assign slaveOn  = portEnable & isSlave & !ssBlock;
  assign busy     = (state == SSP_SHIFT) | (isSlave & (bitCnt != 3'h0));
  // [R16] collision must be cleared first
  assign wrOk     = wrData & !busy & !writeCollision;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and master rate generator.
  ssp_sync2 #(
    .WIDTH (3)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .asyncIn  ({sckIn, sdiIn, ssN}),
    .syncOut  ({sckS, sdiS, ssS})
  );

  ssp_clk_div u_div (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .run        (state == SSP_SHIFT),
    .rateSel    (portMode),
    .timerPulse (timerOut),
    .halfTick   (halfTick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Shift, sample and completion events.
  logic       mTick;      // Master half-period boundary.
  logic       lead;       // Boundary is an idle-to-active edge.
  logic       inByte;     // Boundary still toggles the clock.
  logic       mSample;    // Master captures data in.
  logic       mShift;     // Master presents next bit.
  logic       mDone;      // Master byte finished.
  logic       sckLead;    // Slave sees idle-to-active edge.
  logic       sckTrail;   // Slave sees active-to-idle edge.
  logic       sSample;    // Slave captures data in.
  logic       sShift;     // Slave presents next bit.
  logic       rxComplete; // Eight bits received.
  logic       overflow;   // Completed byte must be dropped.
  logic [7:0] doneByte;   // Byte that completed.

  assign mTick    = (state == SSP_SHIFT) & halfTick;
  assign lead     = !halfIdx[0];
  assign inByte   = halfIdx < HALF_LAST;
  // [R3] sample in the middle, or with the next output change
  assign mSample  = mTick & (sampleEnd ?
                    (edgeSel ? (!lead & inByte) : (lead & (halfIdx != 5'h00))) :
                    ((edgeSel ? lead : !lead) & inByte));
  // [R5] output change edge
  assign mShift   = mTick & inByte & (edgeSel ? !lead : (lead & (halfIdx != 5'h00)));
  assign mDone    = mTick & (halfIdx == HALF_LAST);
  // [R20] slave edges come from the partner's clock
  assign sckLead  = (sckPrev == clockPolarity) & (sckS != clockPolarity);
  assign sckTrail = (sckPrev != clockPolarity) & (sckS == clockPolarity);
  assign sSample  = slaveOn & (edgeSel ? sckLead : sckTrail);
  assign sShift   = slaveOn & (edgeSel ? sckTrail : (sckLead & (bitCnt != 3'h0)));
  // [R1] eight samples make a byte
  assign rxComplete = mDone | (sSample & (bitCnt == BIT_LAST));
  // [R2] a sample on the completing edge enters at the bottom
  assign doneByte = (mSample | sSample) ? {rxShift[6:0], sdiS} : rxShift;
  // [R17] slave only; a same-edge read has already taken the old byte, so no overflow
  assign overflow = rxComplete & isSlave & bufferFull & !rdData;

  ////////////////////////////////////////////////////////////////////////
  // Wishbone answer: ack one cycle after the request, for one cycle.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
    end
    else if (ce)
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & !wb_ack_o;
    end
  end

  // Read data is registered together with ack; unmapped reads give zero.
  always_comb
  begin
    readMux = 8'h00;
    if (regSel(wb_adr_i, OFS_STATUS))
    begin
      readMux = {sampleEnd, edgeSel, 5'h00, bufferFull};
    end
    else if (regSel(wb_adr_i, OFS_CONTROL))
    begin
      readMux = {writeCollision, receiveOverflow, portEnable, clockPolarity, portMode};
    end
    else if (regSel(wb_adr_i, OFS_DATA))
    begin
      // [R18] the shifter is only seen through the buffer
      readMux = dataBuffer;
    end
    else if (regSel(wb_adr_i, OFS_EVENT))
    begin
      readMux = {7'h00, transferDone};
    end
  end

  // Captures read data in the cycle ack rises.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce && wb_cyc_i && wb_stb_i && !wb_ack_o)
    begin
      wb_dat_o <= {24'h00_0000, readMux};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sampleEnd     <= RST_STATUS[ST_SAMPLE];
      edgeSel       <= RST_STATUS[ST_EDGE];
      portEnable    <= RST_CONTROL[CT_EN];
      clockPolarity <= RST_CONTROL[CT_CKP];
      portMode      <= RST_CONTROL[3:0];
    end
    else if (ce)
    begin
      if (wrStat)
      begin
        sampleEnd <= wb_dat_i[ST_SAMPLE];
        edgeSel   <= wb_dat_i[ST_EDGE];
      end
      if (wrCtrl)
      begin
        // [R9] enable bit owns the pins
        portEnable    <= wb_dat_i[CT_EN];
        clockPolarity <= wb_dat_i[CT_CKP];
        portMode      <= wb_dat_i[3:0];
      end
    end
  end

  // Error flags: hardware sets win over software clears by writing zero.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      writeCollision  <= RST_CONTROL[CT_WRITE_COLLISION];
      receiveOverflow <= RST_CONTROL[CT_OVF];
    end
    else if (ce)
    begin
      // [R15] busy write raises collision
      if (wrData && busy)
      begin
        writeCollision <= 1'b1;
      end
      else if (wrCtrl && !wb_dat_i[CT_WRITE_COLLISION])
      begin
        writeCollision <= 1'b0;
      end
      // [R17] overflow raised on a lost slave byte
      if (overflow)
      begin
        receiveOverflow <= 1'b1;
      end
      else if (wrCtrl && !wb_dat_i[CT_OVF])
      begin
        receiveOverflow <= 1'b0;
      end
    end
  end

  // Buffer-full and completion flags; a new byte wins over a clear.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      bufferFull   <= RST_STATUS[ST_FULL];
      transferDone <= 1'b0;
    end
    else if (ce)
    begin
      // [R14] set on a stored byte, cleared by a buffer read
      if (rxComplete && !overflow)
      begin
        bufferFull <= 1'b1;
      end
      else if (rdData)
      begin
        bufferFull <= 1'b0;
      end
      // [R11] completion flag, write one to clear
      if (rxComplete)
      begin
        transferDone <= 1'b1;
      end
      else if (wrEvt && wb_dat_i[EV_DONE])
      begin
        transferDone <= 1'b0;
      end
    end
  end

  // Data buffer: loaded by accepted writes and by completed bytes.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      dataBuffer <= RST_DATA;
    end
    else if (ce)
    begin
      // [R13] write goes to buffer and shifter together
      if (wrOk)
      begin
        dataBuffer <= wb_dat_i[7:0];
      end
      // [R12] shifter frees up once its byte is parked here
      else if (rxComplete && !overflow)
      begin
        dataBuffer <= doneByte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Master engine: a write starts it, the tick walks sixteen edges.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state   <= SSP_IDLE;
      halfIdx <= 5'h00;
    end
    else if (ce)
    begin
      // [R26] disable or a non-master mode aborts the byte
      if (!portEnable || !isMaster)
      begin
        state   <= SSP_IDLE;
        halfIdx <= 5'h00;
      end
      else
      begin
        unique case (state)
          SSP_IDLE:
          begin
            // [R23] accepted write starts the exchange
            if (wrOk)
            begin
              state   <= SSP_SHIFT;
              halfIdx <= 5'h00;
            end
          end
          SSP_SHIFT:
          begin
            if (halfTick && (halfIdx == HALF_LAST))
            begin
              state <= SSP_IDLE;
            end
            else if (halfTick)
            begin
              halfIdx <= halfIdx + 5'h01;
            end
          end
          default:
          begin
            state <= SSP_IDLE;
          end
        endcase
      end
    end
  end

  // Serial clock output: idle level between bytes, toggles on the first sixteen ticks of a byte.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sckOut <= 1'b0;
      sckOe  <= 1'b0;
    end
    else if (ce)
    begin
      sckOe <= portEnable & isMaster;
      // [R20] master drives the clock
      if (mTick && inByte)
      begin
        sckOut <= !sckOut;
      end
      // [R6] idle level follows polarity
      else if (state == SSP_IDLE)
      begin
        sckOut <= clockPolarity;
      end
    end
  end

  // Slave edge history and bit counter.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sckPrev <= 1'b0;
      bitCnt  <= 3'h0;
    end
    else if (ce)
    begin
      sckPrev <= sckS;
      // [R24] [R26] select release or disable zeroes the count
      if (!portEnable || ssBlock || !isSlave)
      begin
        bitCnt <= 3'h0;
      end
      else if (sSample)
      begin
        bitCnt <= bitCnt + 3'h1;
      end
    end
  end

  // Shifter halves: MSB out first, new bits enter at the bottom.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      txShift <= RST_DATA;
      rxShift <= RST_DATA;
    end
    else if (ce)
    begin
      // [R2] [R13] load, then shift toward the MSB
      if (wrOk)
      begin
        txShift <= wb_dat_i[7:0];
      end
      else if (mShift || sShift)
      begin
        txShift <= {txShift[6:0], 1'b0};
      end
      // [R1] capture on the edge opposite to output, or on the output edge when sampleEnd is set in a master mode
      if (mSample || sSample)
      begin
        rxShift <= {rxShift[6:0], sdiS};
      end
    end
  end

  // Data out enable and pin ownership.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sdoOe      <= 1'b0;
      pinsSerial <= 1'b0;
    end
    else if (ce)
    begin
      // [R9] [R24] drive only when enabled; slave with select also needs select low
      sdoOe      <= portEnable & (isMaster | slaveOn);
      pinsSerial <= portEnable;
    end
  end

  assign sdoOut = txShift[7];

  ////////////////////////////////////////////////////////////////////////
  // Checks on the block's own behaviour.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence masterStart;
    ce && wrOk && isMaster && portEnable && (state == SSP_IDLE);
  endsequence

  master_start_a: assert property (masterStart |=> state == SSP_SHIFT) // [R23]
    else $error("master write did not start a byte");
  buf_full_a: assert property (ce && rxComplete && !overflow |=> bufferFull && transferDone) // [R11]
    else $error("completed byte did not set flags");
  buf_load_a: assert property (ce && rxComplete && !overflow |=> dataBuffer == $past(doneByte)) // [R11]
    else $error("completed byte not in buffer");
  read_clear_a: assert property (ce && rdData && !rxComplete |=> !bufferFull) // [R14]
    else $error("buffer read did not clear full flag");
  write_collision_set_a: assert property (ce && wrData && busy && !mDone |=> writeCollision && state == $past(state)) // [R15]
    else $error("busy write not flagged");
  ovf_keep_a: assert property (ce && overflow |=> receiveOverflow && dataBuffer == $past(dataBuffer)) // [R17]
    else $error("overflow byte not dropped");
  ss_release_a: assert property (ce && ssBlock |=> !sdoOe && bitCnt == 3'h0) // [R24]
    else $error("select release ignored");
  off_abort_a: assert property (ce && !portEnable |=> state == SSP_IDLE && !sdoOe && !sckOe) // [R26]
    else $error("disable did not abort");
  idle_level_a: assert property (ce && state == SSP_IDLE ##1 ce && state == SSP_IDLE
                                 |=> sckOut == $past(clockPolarity)) // [R6]
    else $error("clock idle level wrong");
  byte_edges_a: assert property (ce && mDone |-> halfIdx == HALF_LAST && sckOut == clockPolarity) // [R1]
    else $error("master byte ended off idle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over two cycles");
endmodule

// File: bench/ssp_spi_partner.sv
// Behavioural SPI slave that faces the port in master mode.
// Assumes load pulses while the serial clock rests at its idle level.
`timescale 1ns/1ps
module ssp_spi_partner (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       pol,
  input  wire logic       edgeSel,
  input  wire logic       load,
  input  wire logic [7:0] txByte,
  output logic            miso,
  output logic [7:0]      rxByte
);
  logic [7:0] txShift; // Outgoing bits, top bit on the wire.
  logic       prevSck; // Last clock level seen.
  logic       first;   // Holds the top bit over the first active edge.
  ////////////////////////////////////////////////////////////////
  // Top bit first.
  assign miso = txShift[7];
  // Opposite edges, same polarity; vacated bits toggle so stale data never looks valid.
  always @(posedge load, sck)
  begin
    if (load)
    begin
      txShift = txByte;
      prevSck = pol;
      first = 1'b1;
    end
    else if (sck !== prevSck)
    begin
      prevSck = sck;
      if ((sck != pol) == edgeSel)
        rxByte = {rxByte[6:0], mosi};
      else if (first && !edgeSel)
        first = 1'b0;
      else
        txShift = {txShift[6:0], ~txShift[7]};
    end
  end
endmodule

// File: bench/ssp_spi_port_tb_top.sv
// Self-checking bench: the port as master against a behavioural slave.
// Assumes the register offsets and field positions of the shared package.
`timescale 1ns/1ps
module ssp_spi_port_tb_top;
  import ssp_pkg::*;
  logic        core_clk, rst_n, cyc, we, ack, tmr, ld, pol, edg, sample_phase, sdi, sdo, sckOut, pinsSerial;
  logic        sckOe, sdoOe, sckP, ssP, sdiP, slv;
  logic [3:0]  adr;
  logic [2:0]  tcnt;
  logic [7:0]  rnd, ptx, mtx, rxB;
  logic [31:0] dat, rdat, dq, q;
  logic [7:0]  expQ[$];
  int          errTotal, numChecks, n;
  ////////////////////////////////////////////////////////////////
  ssp_spi_port DUT (.core_clk(core_clk), .rst_n(rst_n), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .timerOut(tmr), .sckIn(sckP), .sckOut(sckOut), .sckOe(sckOe), .sdiIn(slv ? sdiP : sdi), .sdoOut(sdo),
    .sdoOe(sdoOe), .ssN(ssP), .pinsSerial(pinsSerial));
  ssp_spi_partner slave (.sck(sckOut), .mosi(sdo), .pol(pol), .edgeSel(edg), .load(ld),
    .txByte(ptx), .miso(sdi), .rxByte(rxB));
  // Clock of 20 ns and a timer pulse every eighth cycle.
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    tcnt <= tcnt + 3'h1;
    tmr <= (tcnt == 3'h7);
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // One classic Wishbone cycle; waits for the acknowledge.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] r);
    int k;
    k = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    chk("ack", 32'h1, {31'h0, ack});
    r = rdat;
    cyc <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e)
    begin
      errTotal++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    chk(nm, e, r);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    {rst_n, cyc, we, ld, pol, edg, sample_phase, tmr} = 8'h00;
    {adr, tcnt, dat, ptx, sckP, sdiP, slv} = 0;
    ssP = 1'b1;
    rnd = 8'h23;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (int a = 0; a < 5; a++)
      rdc("reset", (a == 4) ? 4'h1 : 4'(4 * a), 32'h00000000);
    // Core/4 is too fast for middle sampling through the pin synchroniser.
    for (int m = 0; m < 4; m++)
      for (int c = (m == 0) ? 4 : 0; c < 8; c++)
      begin
        {sample_phase, edg, pol} = 3'(c);
        bus(1'b1, OFS_CONTROL, 8'h00, dq);
        bus(1'b1, OFS_STATUS, {sample_phase, edg, 6'h00}, dq);
        chk("pinsOff", 32'h0, {29'h0, sckOe, sdoOe, pinsSerial});
        bus(1'b1, OFS_CONTROL, {3'h1, pol, 4'(m)}, dq);
        rnd = lfsr(rnd);
        ptx <= rnd;
        expQ.push_back(rnd);
        rnd = lfsr(rnd);
        mtx = rnd;
        ld <= 1'b1;
        @(posedge core_clk);
        ld <= 1'b0;
        chk("sckIdle", {31'h0, pol}, {31'h0, sckOut});
        chk("pinsSerial", 32'h7, {29'h0, sckOe, sdoOe, pinsSerial});
        bus(1'b1, OFS_DATA, mtx, dq);
        bus(1'b1, OFS_DATA, ~mtx, dq);
        rdc("collision", OFS_CONTROL, {24'h0, 3'h5, pol, 4'(m)});
        n = 0;
        q = 0;
        while (q[0] !== 1'b1 && n < 400)
        begin
          bus(1'b0, OFS_EVENT, 8'h00, q);
          n++;
        end
        chk("done", 32'h1, {31'h0, q[0]});
        rdc("full", OFS_STATUS, {24'h0, sample_phase, edg, 6'h01});
        rdc("rxByte", OFS_DATA, {24'h0, expQ.pop_front()});
        chk("slaveRx", {24'h0, mtx}, {24'h0, rxB});
        rdc("empty", OFS_STATUS, {24'h0, sample_phase, edg, 6'h00});
        bus(1'b1, OFS_EVENT, 8'h01, dq);
        $display("test mode %0d setting %0d ended", m, c);
      end
    // Slave with select, idle-low clock, capture on the rising edge.
    slv <= 1'b1;
    bus(1'b1, OFS_CONTROL, 8'h00, dq);
    bus(1'b1, OFS_STATUS, 8'h40, dq);
    bus(1'b1, OFS_CONTROL, 8'h24, dq);
    rnd = lfsr(rnd);
    ssP <= 1'b0;
    for (int b = 7; b >= 0; b--)
    begin
      sdiP <= rnd[b];
      repeat (4) @(posedge core_clk);
      sckP <= 1'b1;
      repeat (4) @(posedge core_clk);
      sckP <= 1'b0;
    end
    repeat (6) @(posedge core_clk);
    ssP <= 1'b1;
    rdc("slvByte", OFS_DATA, {24'h0, rnd});
    $display("test slave ended");
    conclude();
  end
  // Cuts a hang short.
  initial
  begin
    repeat (60000) @(posedge core_clk);
    errTotal++;
    conclude();
  end
endmodule
